//--- rtl/gtm_pkg.sv
// gtm_pkg: register map, field positions and reset values of the gated timer
package gtm_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_TIMER_CTRL = 12'h000;
   localparam logic [11:0] ADDR_GATE_CTRL  = 12'h004;
   localparam logic [11:0] ADDR_COUNT_LOW  = 12'h008;
   localparam logic [11:0] ADDR_COUNT_HIGH = 12'h00C;
   localparam logic [11:0] ADDR_FLAG       = 12'h010;
   localparam logic [11:0] ADDR_ENABLE     = 12'h014;
   localparam logic [11:0] ADDR_IRQ_CTRL   = 12'h018;
   // ----------------------------------------------------------------
   // timer control fields
   // ----------------------------------------------------------------
   localparam int TC_TIMER_ON  = 0;
   localparam int TC_NO_SYNC   = 2;
   localparam int TC_OSC_EN    = 3;
   localparam int TC_CS_LO     = 6;
   // ----------------------------------------------------------------
   // gate control fields
   // ----------------------------------------------------------------
   localparam int GC_SS_LO     = 0;
   localparam int GC_VAL       = 2;
   localparam int GC_GO_DONE   = 3;
   localparam int GC_SPM       = 4;
   localparam int GC_TM        = 5;
   localparam int GC_POL       = 6;
   localparam int GC_GE        = 7;
   // ----------------------------------------------------------------
   // flag / enable / irq control fields
   // ----------------------------------------------------------------
   localparam int FL_OVF       = 0;
   localparam int FL_GATE      = 7;
   localparam int IC_PERIPHERAL_IRQ_ENABLE      = 6;
   localparam int IC_GIE       = 7;
   // ----------------------------------------------------------------
   // gate sources and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_PIN  = 2'h0;
   localparam logic [1:0] SRC_OVF8 = 2'h1;
   localparam logic [1:0] SRC_CMPA = 2'h2;
   localparam logic [1:0] SRC_CMPB = 2'h3;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

//--- rtl/gtm_sync3.sv
// gtm_sync3: three-stage synchroniser, output changes when stages 2 and 3 agree
module gtm_sync3 (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // data
   input  wire logic d,
   output logic      q
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q  <= 1'b0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q <= s3;
         end
      end
   end
endmodule

//--- rtl/gtm_top.sv
// gtm_top: gated 16-bit timer with gate logic, flags and apb registers
// Overview of operation
// - counter bytes read coherently despite async clock
// - gate enable counts only while gate active
// - polarity bit selects active gate level
// - two-bit field selects one of four sources
// - 8-bit timer wrap makes internal gate pulse
// - comparator gate optionally synchronised or raw
// - toggle flip-flop flips on each active gate source edge
// - toggle mode off holds flip-flop clear
// - go arms, edge enables, trailing edge clears
// - no counting after acquisition until rearmed
// - clearing single-pulse enable clears go/done
// - toggle plus single-pulse measures one full cycle
// - gate value bit valid without gate enable
// - gate value falling edge sets gate flag
// - gate flag works with gate enable clear
// - counter wrap sets overflow flag
// - overflow irq needs on, enables, peripheral_irq_enable, gie
// - sleep wake needs async counter mode
// - overflow during sleep wakes the core
// - timer off ignores gate, clears toggle
//
// The APB slave port and the address map were chosen for this implementation.
module gtm_top (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // timer clock and gate sources (all from outside mclk)
   input  wire logic        count_clk_pin,
   input  wire logic        gate_input_pin,
   input  wire logic        comparator_a_out,
   input  wire logic        comparator_b_out,
   input  wire logic        comparator_a_sync_sel,
   input  wire logic        comparator_b_sync_sel,
   // companion 8-bit timer tick (same clock)
   input  wire logic        companion_tick,
   // core status
   input  wire logic        sleep_mode,
   // outputs
   output logic             irq,
   output logic             wake,
   output logic             dedicated_osc_run
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  timer_control_reg;
   logic [7:0]  gate_control_bits;
   logic [7:0]  peripheral_enable_reg;
   logic [7:0]  irq_control_reg;
   logic [15:0] count;
   logic [7:0]  companion_8bit_timer;
   logic        overflow_flag;
   logic        gate_event_flag;
   logic        single_pulse_go_done;
   logic        toggle_ff;
   logic        gate_value_status;
   logic        gate_val_d;
   logic        gate_lvl_d;
   logic        sp_counting;
   logic [7:0]  low_latch;

   logic timer_on;
   logic gate_enable;
   logic gate_polarity;
   logic gate_toggle_mode;
   logic gate_single_pulse_mode;
   logic no_sync_select;
   logic [1:0] gate_source_select;
   logic overflow_irq_enable;
   logic gate_event_irq_enable;
   logic peripheral_irq_enable;
   logic global_irq_enable;

   assign timer_on               = timer_control_reg[gtm_pkg::TC_TIMER_ON];
   assign no_sync_select         = timer_control_reg[gtm_pkg::TC_NO_SYNC];
   assign gate_enable            = gate_control_bits[gtm_pkg::GC_GE];
   assign gate_polarity          = gate_control_bits[gtm_pkg::GC_POL];
   assign gate_toggle_mode       = gate_control_bits[gtm_pkg::GC_TM];
   assign gate_single_pulse_mode = gate_control_bits[gtm_pkg::GC_SPM];
   assign gate_source_select     = gate_control_bits[gtm_pkg::GC_SS_LO +: 2];
   assign overflow_irq_enable    = peripheral_enable_reg[gtm_pkg::FL_OVF];
   assign gate_event_irq_enable  = peripheral_enable_reg[gtm_pkg::FL_GATE];
   assign peripheral_irq_enable  = irq_control_reg[gtm_pkg::IC_PERIPHERAL_IRQ_ENABLE];
   assign global_irq_enable      = irq_control_reg[gtm_pkg::IC_GIE];

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic clk_s;
   logic pin_s;
   logic cmpa_s;
   logic cmpb_s;
   logic cmpa_t;
   logic cmpb_t;

   // async clock crossed into mclk so byte reads never tear
   gtm_sync3 u_sync_clk  (.mclk(mclk), .rst(rst), .d(count_clk_pin),    .q(clk_s));
   gtm_sync3 u_sync_pin  (.mclk(mclk), .rst(rst), .d(gate_input_pin),   .q(pin_s));
   gtm_sync3 u_sync_cmpa (.mclk(mclk), .rst(rst), .d(comparator_a_out), .q(cmpa_s));
   gtm_sync3 u_sync_cmpb (.mclk(mclk), .rst(rst), .d(comparator_b_out), .q(cmpb_s));

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign addr_ok = (paddr == gtm_pkg::ADDR_TIMER_CTRL) | (paddr == gtm_pkg::ADDR_GATE_CTRL) |
                    (paddr == gtm_pkg::ADDR_COUNT_LOW)  | (paddr == gtm_pkg::ADDR_COUNT_HIGH) |
                    (paddr == gtm_pkg::ADDR_FLAG)       | (paddr == gtm_pkg::ADDR_ENABLE) |
                    (paddr == gtm_pkg::ADDR_IRQ_CTRL);
   assign pslverr = psel & penable & ~addr_ok;

   logic wr_tc;
   logic wr_gc;
   logic wr_lo;
   logic wr_hi;
   logic wr_fl;

   assign wr_tc = wr_en & (paddr == gtm_pkg::ADDR_TIMER_CTRL);
   assign wr_gc = wr_en & (paddr == gtm_pkg::ADDR_GATE_CTRL);
   assign wr_lo = wr_en & (paddr == gtm_pkg::ADDR_COUNT_LOW);
   assign wr_hi = wr_en & (paddr == gtm_pkg::ADDR_COUNT_HIGH);
   assign wr_fl = wr_en & (paddr == gtm_pkg::ADDR_FLAG);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timer_control_reg     <= gtm_pkg::RST_BYTE;
         gate_control_bits     <= gtm_pkg::RST_BYTE;
         peripheral_enable_reg <= gtm_pkg::RST_BYTE;
         irq_control_reg       <= gtm_pkg::RST_BYTE;
      end else if (wr_en) begin
         if (wr_tc) begin
            timer_control_reg <= pwdata[7:0] & 8'hFD;
         end
         if (wr_gc) begin
            gate_control_bits <= pwdata[7:0] & 8'hF3;
         end
         if (paddr == gtm_pkg::ADDR_ENABLE) begin
            peripheral_enable_reg <= pwdata[7:0] & 8'h81;
         end
         if (paddr == gtm_pkg::ADDR_IRQ_CTRL) begin
            irq_control_reg <= pwdata[7:0] & 8'hC0;
         end
      end
   end

   // ----------------------------------------------------------------
   // companion 8-bit timer and its overflow pulse
   // ----------------------------------------------------------------
   logic ovf8_pulse;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         companion_8bit_timer <= gtm_pkg::RST_BYTE;
      end else if (companion_tick) begin
         companion_8bit_timer <= companion_8bit_timer + 8'h01;
      end
   end
   assign ovf8_pulse = companion_tick & (companion_8bit_timer == 8'hFF);

   // ----------------------------------------------------------------
   // gate source selection, polarity, registered level
   // ----------------------------------------------------------------
   logic src_lvl;
   logic gate_lvl;

   always_comb begin
      case (gate_source_select)
         gtm_pkg::SRC_PIN:  src_lvl = pin_s;
         gtm_pkg::SRC_OVF8: src_lvl = ovf8_pulse;
         // raw option still passes the three flops; sync option adds count clock retiming
         gtm_pkg::SRC_CMPA: src_lvl = comparator_a_sync_sel ? cmpa_t : cmpa_s;
         gtm_pkg::SRC_CMPB: src_lvl = comparator_b_sync_sel ? cmpb_t : cmpb_s;
         default:           src_lvl = 1'b0;
      endcase
   end

   logic src_reg;
   logic src_reg_d;
   logic act_edge;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         src_reg   <= 1'b0;
         src_reg_d <= 1'b0;
      end else begin
         src_reg   <= src_lvl ~^ gate_polarity;
         src_reg_d <= src_reg;
      end
   end
   assign act_edge = src_reg & ~src_reg_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         toggle_ff <= 1'b0;
      end else if (!gate_toggle_mode || !timer_on) begin
         toggle_ff <= 1'b0;
      end else if (act_edge) begin
         toggle_ff <= ~toggle_ff;
      end
   end

   assign gate_lvl = gate_toggle_mode ? toggle_ff : src_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_lvl_d <= 1'b0;
      end else begin
         gate_lvl_d <= gate_lvl;
      end
   end

   // ----------------------------------------------------------------
   // single-pulse sequencer
   // ----------------------------------------------------------------
   logic gate_rise;
   logic gate_fall;

   assign gate_rise = gate_lvl & ~gate_lvl_d;
   assign gate_fall = ~gate_lvl & gate_lvl_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         single_pulse_go_done <= 1'b0;
         sp_counting          <= 1'b0;
      end else if (!gate_single_pulse_mode || (wr_gc && !pwdata[gtm_pkg::GC_SPM])) begin
         single_pulse_go_done <= 1'b0;
         sp_counting          <= 1'b0;
      end else if (wr_gc && pwdata[gtm_pkg::GC_GO_DONE] && !single_pulse_go_done) begin
         single_pulse_go_done <= 1'b1;
         sp_counting          <= 1'b0;
      end else if (single_pulse_go_done && !sp_counting && gate_rise) begin
         sp_counting <= 1'b1;
      end else if (sp_counting && gate_fall) begin
         single_pulse_go_done <= 1'b0;
         sp_counting          <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // gate value, counting qualifier
   // ----------------------------------------------------------------
   logic gate_open;
   logic inc;
   logic clk_s_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_value_status <= 1'b0;
         gate_val_d        <= 1'b0;
         clk_s_d           <= 1'b0;
      end else begin
         gate_value_status <= gate_single_pulse_mode ? (gate_lvl & sp_counting) : gate_lvl;
         gate_val_d        <= gate_value_status;
         clk_s_d           <= clk_s;
      end
   end

   // comparators retimed to count clock edges for the sync option
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmpa_t <= 1'b0;
         cmpb_t <= 1'b0;
      end else if (clk_s && !clk_s_d) begin
         cmpa_t <= cmpa_s;
         cmpb_t <= cmpb_s;
      end
   end

   assign gate_open = ~gate_enable | gate_value_status;
   assign inc       = timer_on & gate_open & clk_s & ~clk_s_d;

   // ----------------------------------------------------------------
   // counter, coherent read latch
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
      end else if (wr_lo) begin
         count[7:0] <= pwdata[7:0];
      end else if (wr_hi) begin
         count[15:8] <= pwdata[7:0];
      end else if (inc) begin
         count <= count + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // flags; a set in the same cycle as a clear wins
   // ----------------------------------------------------------------
   logic ovf_set;
   logic gate_set;

   assign ovf_set  = inc & (count == 16'hFFFF);
   assign gate_set = ~gate_value_status & gate_val_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         overflow_flag   <= 1'b0;
         gate_event_flag <= 1'b0;
      end else begin
         if (ovf_set) begin
            overflow_flag <= 1'b1;
         end else if (wr_fl) begin
            overflow_flag <= pwdata[gtm_pkg::FL_OVF];
         end
         if (gate_set) begin
            gate_event_flag <= 1'b1;
         end else if (wr_fl) begin
            gate_event_flag <= pwdata[gtm_pkg::FL_GATE];
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt and wake
   // ----------------------------------------------------------------
   logic ovf_req;
   logic gate_req;

   assign ovf_req  = overflow_flag & timer_on & overflow_irq_enable & peripheral_irq_enable;
   assign gate_req = gate_event_flag & gate_event_irq_enable & peripheral_irq_enable;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq               <= 1'b0;
         wake              <= 1'b0;
         dedicated_osc_run <= 1'b0;
      end else begin
         irq               <= (ovf_req | gate_req) & global_irq_enable;
         wake              <= sleep_mode & ovf_req & no_sync_select;
         dedicated_osc_run <= timer_control_reg[gtm_pkg::TC_OSC_EN];
      end
   end

   // ----------------------------------------------------------------
   // read mux; low byte read latches high for a coherent pair
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_latch <= gtm_pkg::RST_BYTE;
      end else if (rd_en && paddr == gtm_pkg::ADDR_COUNT_LOW) begin
         low_latch <= count[15:8];
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         gtm_pkg::ADDR_TIMER_CTRL: prdata[7:0] = timer_control_reg;
         gtm_pkg::ADDR_GATE_CTRL:  prdata[7:0] = {gate_control_bits[7:4], single_pulse_go_done,
                                                  gate_value_status, gate_control_bits[1:0]};
         gtm_pkg::ADDR_COUNT_LOW:  prdata[7:0] = count[7:0];
         gtm_pkg::ADDR_COUNT_HIGH: prdata[7:0] = low_latch;
         gtm_pkg::ADDR_FLAG:       prdata[7:0] = {gate_event_flag, 6'h00, overflow_flag};
         gtm_pkg::ADDR_ENABLE:     prdata[7:0] = peripheral_enable_reg;
         gtm_pkg::ADDR_IRQ_CTRL:   prdata[7:0] = irq_control_reg;
         default:                  prdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_HOLD_WHEN_CLOSED: assert property (@(posedge mclk) disable iff (rst)
      (gate_enable && !gate_value_status && !wr_lo && !wr_hi) |=> $stable(count))
      else $error("count moved while gate closed");
   AST_OFF_NO_COUNT: assert property (@(posedge mclk) disable iff (rst)
      (!timer_on && !wr_lo && !wr_hi) |=> $stable(count))
      else $error("count moved while timer off");
   AST_TOGGLE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      !gate_toggle_mode |=> !toggle_ff)
      else $error("toggle flop not held clear");
   AST_OVF_FLAG: assert property (@(posedge mclk) disable iff (rst)
      (inc && count == 16'hFFFF && !wr_lo && !wr_hi) |=> (overflow_flag && count == 16'h0000))
      else $error("wrap did not set overflow flag");
   AST_GATE_FLAG: assert property (@(posedge mclk) disable iff (rst)
      $fell(gate_value_status) |=> gate_event_flag)
      else $error("gate falling edge lost");
   AST_SPM_CLEAR: assert property (@(posedge mclk) disable iff (rst)
      !gate_single_pulse_mode |=> !single_pulse_go_done)
      else $error("go/done not cleared");
   AST_SP_DONE_HOLD: assert property (@(posedge mclk) disable iff (rst)
      (gate_single_pulse_mode && !single_pulse_go_done && !sp_counting) |=> !gate_value_status)
      else $error("gate opened after acquisition");
   AST_IRQ_NEEDS_GIE: assert property (@(posedge mclk) disable iff (rst)
      irq |-> $past(global_irq_enable) && $past(peripheral_irq_enable))
      else $error("irq without enables");
   AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
      (sleep_mode && ovf_req && no_sync_select) |=> wake)
      else $error("overflow in sleep did not wake");
endmodule

//--- verif/gtm_sources.sv
// gtm_sources: behavioural model of the count clock and the gate sources
module gtm_sources (
   // clock
   input  wire logic mclk,
   // driven sources
   output logic      count_clk_pin,
   output logic      gate_input_pin,
   output logic      comparator_a_out,
   output logic      comparator_b_out,
   output logic      companion_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      count_clk_pin    = 1'b0;
      gate_input_pin   = 1'b0;
      comparator_a_out = 1'b0;
      comparator_b_out = 1'b0;
      companion_tick   = 1'b0;
   end
   // ----------------------------------------------------------------
   // count clock: wide pulses so the three-flop sync sees every edge
   // ----------------------------------------------------------------
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk) count_clk_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         count_clk_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
      repeat (8) @(posedge mclk);
   endtask
   // ----------------------------------------------------------------
   // gate levels, then settle past the gate path latency
   // ----------------------------------------------------------------
   task automatic set_gate(input logic p, input logic a, input logic b);
      @(posedge mclk) gate_input_pin <= p;
      comparator_a_out <= a;
      comparator_b_out <= b;
      repeat (12) @(posedge mclk);
   endtask
   // companion ticks, one every other cycle
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk) companion_tick <= 1'b1;
         @(posedge mclk) companion_tick <= 1'b0;
      end
      repeat (12) @(posedge mclk);
   endtask
endmodule

//--- verif/gtm_top_bench.sv
// gtm_top_bench: directed self-checking bench for the gated timer
module gtm_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, sa, sb, sleep_mode, irq, wake, osc_run;
   logic ck, gp, ca, cb, tk, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int errors, total_checks, cycles;
   gtm_sources src (.mclk(mclk), .count_clk_pin(ck), .gate_input_pin(gp), .comparator_a_out(ca),
                    .comparator_b_out(cb), .companion_tick(tk));
   gtm_top uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clk_pin(ck),
                .gate_input_pin(gp), .comparator_a_out(ca), .comparator_b_out(cb), .comparator_a_sync_sel(sa),
                .comparator_b_sync_sel(sb), .companion_tick(tk), .sleep_mode(sleep_mode), .irq(irq),
                .wake(wake), .dedicated_osc_run(osc_run));
   // ----------------------------------------------------------------
   // clock, timeout, checking and apb tasks
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // no wait count assumed: loop until pready, bounded by the timeout
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(r & m, e);
   endtask
   task automatic rd_cnt(input logic [15:0] e);
      rd(gtm_pkg::ADDR_COUNT_LOW, 32'hFF, {24'h0, e[7:0]});
      rd(gtm_pkg::ADDR_COUNT_HIGH, 32'hFF, {24'h0, e[15:8]});
   endtask
   // stop first, then load, so no increment collides with the write
   task automatic load(input logic [15:0] v);
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h0);
      apb(1'b1, gtm_pkg::ADDR_COUNT_LOW, {24'h0, v[7:0]});
      apb(1'b1, gtm_pkg::ADDR_COUNT_HIGH, {24'h0, v[15:8]});
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_map();
      rd(gtm_pkg::ADDR_TIMER_CTRL, 32'hFFFFFFFF, 32'h0);
      rd(gtm_pkg::ADDR_FLAG, 32'hFFFFFFFF, 32'h0);
      rd_cnt(16'h0000);
      apb(1'b1, 12'h01C, 32'hFF);
      check({31'h0, last_err}, 32'h1);
      rd(12'h01C, 32'hFFFFFFFF, 32'h0);
   endtask
   task automatic t_on_off();
      load(16'h0000);
      src.pulses(3);
      rd_cnt(16'h0000);
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h1);
      src.pulses(5);
      rd_cnt(16'h0005);
   endtask
   task automatic t_gate_pin();
      load(16'h0000);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hC0);
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h1);
      src.set_gate(1'b0, 1'b1, 1'b1);
      src.pulses(4);
      rd_cnt(16'h0000);
      src.set_gate(1'b1, 1'b0, 1'b0);
      src.pulses(4);
      rd_cnt(16'h0004);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'h80);
      src.pulses(2);
      rd_cnt(16'h0004);
      src.set_gate(1'b0, 1'b0, 1'b0);
      src.pulses(2);
      rd_cnt(16'h0006);
   endtask
   task automatic t_comparators();
      for (int i = 0; i < 4; i++) begin
         sa <= i[0];
         sb <= i[0];
         load(16'h0000);
         apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hC2 + i[1]);
         apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h1);
         src.set_gate(1'b0, !i[1], i[1]);
         src.pulses(2);
         src.set_gate(1'b1, i[1], !i[1]);
         src.pulses(2);
         rd_cnt(16'h0002);
      end
   endtask
   task automatic t_gate_value();
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'h40);
      apb(1'b1, gtm_pkg::ADDR_FLAG, 32'h0);
      src.set_gate(1'b1, 1'b0, 1'b0);
      rd(gtm_pkg::ADDR_GATE_CTRL, 32'h4, 32'h4);
      rd(gtm_pkg::ADDR_FLAG, 32'h80, 32'h0);
      src.set_gate(1'b0, 1'b0, 1'b0);
      rd(gtm_pkg::ADDR_GATE_CTRL, 32'h4, 32'h0);
      rd(gtm_pkg::ADDR_FLAG, 32'h80, 32'h80);
      apb(1'b1, gtm_pkg::ADDR_FLAG, 32'h0);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'h41);
      src.ticks(255);
      rd(gtm_pkg::ADDR_FLAG, 32'h80, 32'h0);
      src.ticks(1);
      rd(gtm_pkg::ADDR_FLAG, 32'h80, 32'h80);
      apb(1'b1, gtm_pkg::ADDR_ENABLE, 32'h80);
      apb(1'b1, gtm_pkg::ADDR_IRQ_CTRL, 32'hC0);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
   endtask
   task automatic t_overflow();
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'h0);
      load(16'hFFFF);
      apb(1'b1, gtm_pkg::ADDR_FLAG, 32'h0);
      apb(1'b1, gtm_pkg::ADDR_ENABLE, 32'h1);
      apb(1'b1, gtm_pkg::ADDR_IRQ_CTRL, 32'h40);
      sleep_mode <= 1'b1;
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h0D);
      src.pulses(1);
      rd_cnt(16'h0000);
      rd(gtm_pkg::ADDR_FLAG, 32'h1, 32'h1);
      check({29'h0, irq, wake, osc_run}, 32'h3);
      apb(1'b1, gtm_pkg::ADDR_IRQ_CTRL, 32'hC0);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, gtm_pkg::ADDR_ENABLE, 32'h0);
      repeat (2) @(posedge mclk);
      check({30'h0, irq, wake}, 32'h0);
      sleep_mode <= 1'b0;
   endtask
   task automatic t_single_pulse();
      load(16'h0000);
      src.set_gate(1'b0, 1'b0, 1'b0);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hD0);
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h1);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hD8);
      rd(gtm_pkg::ADDR_GATE_CTRL, 32'h8, 32'h8);
      src.set_gate(1'b1, 1'b0, 1'b0);
      src.pulses(3);
      src.set_gate(1'b0, 1'b0, 1'b0);
      rd(gtm_pkg::ADDR_GATE_CTRL, 32'h8, 32'h0);
      src.set_gate(1'b1, 1'b0, 1'b0);
      src.pulses(2);
      rd_cnt(16'h0003);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hD8);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hC0);
      rd(gtm_pkg::ADDR_GATE_CTRL, 32'h8, 32'h0);
   endtask
   task automatic t_toggle();
      load(16'h0000);
      src.set_gate(1'b0, 1'b0, 1'b0);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hC0);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hE0);
      apb(1'b1, gtm_pkg::ADDR_TIMER_CTRL, 32'h1);
      src.set_gate(1'b1, 1'b0, 1'b0);
      src.pulses(2);
      src.set_gate(1'b0, 1'b0, 1'b0);
      src.pulses(2);
      rd_cnt(16'h0004);
      src.set_gate(1'b1, 1'b0, 1'b0);
      src.pulses(2);
      rd_cnt(16'h0004);
      apb(1'b1, gtm_pkg::ADDR_GATE_CTRL, 32'hC0);
      src.set_gate(1'b0, 1'b0, 1'b0);
      src.pulses(1);
      rd_cnt(16'h0004);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, sa, sb, sleep_mode} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_reset_map();
      t_on_off();
      t_gate_pin();
      t_comparators();
      t_gate_value();
      t_overflow();
      t_single_pulse();
      t_toggle();
      give_verdict();
   end
endmodule
